/* File: design/gpb_pkg.sv */
package gpb_pkg;

	// ********************************
	// Timing
	// ********************************
	localparam int CLK_NS      = 40;
	localparam int T_SETTLE_NS = 2000;
	// Data settle before the valid strobe, rounded up to whole cycles.
	localparam logic [7:0] SETTLE_CYC = 8'((T_SETTLE_NS + CLK_NS - 1) / CLK_NS);

	// ********************************
	// Command bytes, low seven bits
	// ********************************
	localparam logic [6:0] LAG_BASE = 7'h20;
	localparam logic [6:0] TAG_BASE = 7'h40;
	localparam logic [6:0] CMD_UNL  = 7'h3F;
	localparam logic [6:0] CMD_UNT  = 7'h5F;
	localparam logic [6:0] CMD_GTL  = 7'h01;
	localparam logic [6:0] CMD_SDC  = 7'h04;
	localparam logic [6:0] CMD_PPC  = 7'h05;
	localparam logic [6:0] CMD_GET  = 7'h08;
	localparam logic [6:0] CMD_DCL  = 7'h14;
	localparam logic [6:0] CMD_PPU  = 7'h15;
	localparam logic [6:0] CMD_SPE  = 7'h18;
	localparam logic [6:0] CMD_SPD  = 7'h19;
	localparam int         RSV_BIT  = 6;

	// ********************************
	// Pin bundles
	// ********************************
	typedef struct packed {
		logic       atn;
		logic       ifc;
		logic       ren;
		logic       eoi;
		logic       dav;
		logic       nrfd;
		logic       ndac;
		logic [7:0] dio;
	} gpb_bus_in_t;

	typedef struct packed {
		logic       srq;
		logic       eoi;
		logic       dav;
		logic       nrfd;
		logic       ndac;
		logic [7:0] dio;
	} gpb_drv_t;

	localparam gpb_drv_t  OE_N_RST  = 13'h1FFF;
	localparam gpb_drv_t  LVL_RST   = 13'h0000;
	localparam logic [7:0] BYTE_RST = 8'h00;

	// ********************************
	// Handshake states
	// ********************************
	typedef enum logic [1:0] {A_OFF, A_NOT, A_RDY, A_ACC} gpb_ah_t;
	typedef enum logic [1:0] {S_IDLE, S_SET, S_DAV} gpb_sh_t;

endpackage

/* File: design/gpb_dev.sv */
`timescale 1ns/10ps

module gpb_dev (
	// Clock and reset
	input  wire logic                 mclk,
	input  wire logic                 rst,
	// Bus lines at wire level, low is true
	input  wire gpb_pkg::gpb_bus_in_t bus_in,
	output gpb_pkg::gpb_drv_t         pin_lvl_ff,
	output gpb_pkg::gpb_drv_t         pin_oe_n_ff,
	// Device settings
	input  wire logic [4:0]           prim_addr,
	input  wire logic                 talk_only,
	// Received data
	output logic [7:0]                rx_data_ff,
	output logic                      rx_valid_ff,
	output logic                      rx_end_ff,
	// Data to send
	input  wire logic [7:0]           tx_data,
	input  wire logic                 tx_end,
	input  wire logic                 tx_valid,
	output logic                      tx_ready_ff,
	// Status and events
	input  wire logic [7:0]           status,
	input  wire logic                 rqs_set,
	output logic                      rsv_ff,
	output logic                      listener_ff,
	output logic                      talker_ff,
	output logic                      remote_ff,
	output logic                      spoll_ff,
	output logic                      dev_clear_ff,
	output logic                      trigger_ff
);

	// ********************************
	// Input synchronisers
	// ********************************
	gpb_pkg::gpb_bus_in_t sync1_ff;
	gpb_pkg::gpb_bus_in_t sync2_ff;
	gpb_pkg::gpb_bus_in_t bus;

	always_ff @(posedge mclk) begin
		if (rst) begin
			sync1_ff <= '1;
			sync2_ff <= '1;
		end else begin
			sync1_ff <= bus_in;
			sync2_ff <= sync1_ff;
		end
	end

	// Lines are active low on the wire; internally true is high.
	assign bus = ~sync2_ff;

	// ********************************
	// Decode
	// ********************************
	gpb_pkg::gpb_ah_t ah_st_ff;
	gpb_pkg::gpb_sh_t sh_st_ff;
	logic [6:0]       cmd;
	logic [6:0]       my_la;
	logic [6:0]       my_ta;
	logic             take_ev;
	logic             cmd_ev;
	logic             data_ev;
	logic             sh_act;
	logic             tx_take;
	logic             sh_done;

	assign my_la   = gpb_pkg::LAG_BASE | {2'b00, prim_addr};
	assign my_ta   = gpb_pkg::TAG_BASE | {2'b00, prim_addr};
	assign cmd     = bus.dio[6:0];
	assign take_ev = (ah_st_ff == gpb_pkg::A_RDY) && bus.dav;
	assign cmd_ev  = take_ev && bus.atn;
	assign data_ev = take_ev && !bus.atn && listener_ff;
	assign sh_act  = talker_ff && !bus.atn && !bus.ifc;
	assign tx_take = sh_act && tx_valid && tx_ready_ff;
	assign sh_done = (sh_st_ff == gpb_pkg::S_DAV) && !bus.ndac;

	// ********************************
	// Addressing
	// ********************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			listener_ff <= 1'b0;
			talker_ff   <= 1'b0;
			spoll_ff    <= 1'b0;
		end else if (bus.ifc) begin
			listener_ff <= 1'b0;
			talker_ff   <= 1'b0;
			spoll_ff    <= 1'b0;
		end else begin
			if (cmd_ev) begin
				if (cmd == gpb_pkg::CMD_UNL) begin
					listener_ff <= 1'b0;
				end else if (cmd == my_la) begin
					listener_ff <= 1'b1;
					talker_ff   <= 1'b0;
				end else if (cmd == gpb_pkg::CMD_UNT) begin
					talker_ff <= 1'b0;
				end else if (cmd == my_ta) begin
					talker_ff   <= 1'b1;
					listener_ff <= 1'b0;
				end else if (cmd[6:5] == 2'b10) begin
					talker_ff <= 1'b0;
				end
				if (cmd == gpb_pkg::CMD_SPE) begin
					spoll_ff <= 1'b1;
				end else if (cmd == gpb_pkg::CMD_SPD) begin
					spoll_ff <= 1'b0;
				end
			end
			if (talk_only) begin
				talker_ff <= 1'b1;
			end
		end
	end

	// ********************************
	// Addressed and universal events
	// ********************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			dev_clear_ff <= 1'b0;
			trigger_ff   <= 1'b0;
		end else begin
			dev_clear_ff <= cmd_ev && ((cmd == gpb_pkg::CMD_DCL)
				|| (cmd == gpb_pkg::CMD_SDC && listener_ff));
			trigger_ff   <= cmd_ev && (cmd == gpb_pkg::CMD_GET) && listener_ff;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			remote_ff <= 1'b0;
		end else if (!bus.ren) begin
			remote_ff <= 1'b0;
		end else if (cmd_ev && cmd == my_la) begin
			remote_ff <= 1'b1;
		end else if (cmd_ev && cmd == gpb_pkg::CMD_GTL && listener_ff) begin
			remote_ff <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			rx_data_ff  <= gpb_pkg::BYTE_RST;
			rx_valid_ff <= 1'b0;
			rx_end_ff   <= 1'b0;
		end else begin
			rx_valid_ff <= data_ev;
			if (data_ev) begin
				rx_data_ff <= bus.dio;
				rx_end_ff  <= bus.eoi;
			end
		end
	end

	// ********************************
	// Acceptor handshake
	// ********************************
	// acceptor sequence
	always_ff @(posedge mclk) begin
		if (rst) begin
			ah_st_ff <= gpb_pkg::A_OFF;
		end else if (!(bus.atn || listener_ff) || bus.ifc) begin
			ah_st_ff <= gpb_pkg::A_OFF;
		end else begin
			case (ah_st_ff)
				gpb_pkg::A_OFF: ah_st_ff <= gpb_pkg::A_NOT;
				gpb_pkg::A_NOT: ah_st_ff <= gpb_pkg::A_RDY;
				gpb_pkg::A_RDY: if (bus.dav) begin
					ah_st_ff <= gpb_pkg::A_ACC;
				end
				gpb_pkg::A_ACC: if (!bus.dav) begin
					ah_st_ff <= gpb_pkg::A_NOT;
				end
				default: ah_st_ff <= gpb_pkg::A_OFF;
			endcase
		end
	end

	// ********************************
	// Source handshake
	// ********************************
	logic [7:0] tx_byte_ff;
	logic       tx_eoi_ff;
	logic [7:0] settle_ff;

	always_ff @(posedge mclk) begin
		if (rst || !sh_act) begin
			sh_st_ff   <= gpb_pkg::S_IDLE;
			tx_byte_ff <= gpb_pkg::BYTE_RST;
			tx_eoi_ff  <= 1'b0;
			settle_ff  <= gpb_pkg::SETTLE_CYC;
		end else begin
			case (sh_st_ff)
				gpb_pkg::S_IDLE: begin
					settle_ff <= gpb_pkg::SETTLE_CYC;
					if (spoll_ff) begin
						tx_byte_ff <= {status[7], rsv_ff, status[5:0]};
						tx_eoi_ff  <= 1'b0;
						sh_st_ff   <= gpb_pkg::S_SET;
					end else if (tx_take) begin
						tx_byte_ff <= tx_data;
						tx_eoi_ff  <= tx_end;
						sh_st_ff   <= gpb_pkg::S_SET;
					end
				end
				gpb_pkg::S_SET: begin
					if (settle_ff != 8'h00) begin
						settle_ff <= settle_ff - 8'h01;
					end else if (!bus.nrfd) begin
						sh_st_ff <= gpb_pkg::S_DAV;
					end
				end
				gpb_pkg::S_DAV: if (!bus.ndac) begin
					sh_st_ff <= gpb_pkg::S_IDLE;
				end
				default: sh_st_ff <= gpb_pkg::S_IDLE;
			endcase
		end
	end

	// The user byte is offered only while idle, so no byte is ever overwritten.
	always_ff @(posedge mclk) begin
		if (rst) begin
			tx_ready_ff <= 1'b0;
		end else begin
			tx_ready_ff <= sh_act && !spoll_ff && !tx_take
				&& (sh_st_ff == gpb_pkg::S_IDLE);
		end
	end

	// request service, set wins over clear
	always_ff @(posedge mclk) begin
		if (rst) begin
			rsv_ff <= 1'b0;
		end else if (rqs_set) begin
			rsv_ff <= 1'b1;
		end else if (sh_done && spoll_ff && tx_byte_ff[gpb_pkg::RSV_BIT]) begin
			rsv_ff <= 1'b0;
		end
	end

	// ********************************
	// Pin drivers
	// ********************************
	// Open-drain: the level is always low and only the enables move.
	always_ff @(posedge mclk) begin
		if (rst) begin
			pin_lvl_ff  <= gpb_pkg::LVL_RST;
			pin_oe_n_ff <= gpb_pkg::OE_N_RST;
		end else begin
			pin_lvl_ff       <= gpb_pkg::LVL_RST;
			pin_oe_n_ff.srq  <= ~rsv_ff;
			pin_oe_n_ff.dav  <= ~(sh_st_ff == gpb_pkg::S_DAV);
			pin_oe_n_ff.eoi  <= ~((sh_st_ff != gpb_pkg::S_IDLE) && tx_eoi_ff);
			pin_oe_n_ff.dio  <= (sh_st_ff != gpb_pkg::S_IDLE) ? ~tx_byte_ff : 8'hFF;
			pin_oe_n_ff.nrfd <= ~(ah_st_ff == gpb_pkg::A_NOT || ah_st_ff == gpb_pkg::A_ACC);
			pin_oe_n_ff.ndac <= ~(ah_st_ff == gpb_pkg::A_NOT || ah_st_ff == gpb_pkg::A_RDY);
		end
	end

	// ********************************
	// Checks
	// ********************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	chk_my_listen_addr: assert property (
		cmd_ev && !bus.ifc && cmd == my_la |=> listener_ff && !talker_ff)
		else $error("my listen address did not make a listener");

	chk_unlisten_drop: assert property (
		cmd_ev && !bus.ifc && cmd == gpb_pkg::CMD_UNL |=> !listener_ff)
		else $error("unlisten left the listener active");

	chk_ifc_idle: assert property (
		bus.ifc |=> !listener_ff && !spoll_ff && ah_st_ff == gpb_pkg::A_OFF)
		else $error("interface clear did not return to idle");

	chk_sdc_needs_listen: assert property (
		cmd_ev && cmd == gpb_pkg::CMD_SDC && !listener_ff |=> !dev_clear_ff)
		else $error("selective clear acted while not listening");

	chk_trigger_pulse: assert property (
		cmd_ev && cmd == gpb_pkg::CMD_GET && listener_ff |=> trigger_ff ##1 !trigger_ff)
		else $error("trigger pulse wrong");

	chk_data_capture: assert property (
		data_ev |=> rx_valid_ff && rx_data_ff == $past(bus.dio))
		else $error("data byte not delivered");

	chk_data_gate: assert property (
		rx_valid_ff |-> $past(listener_ff) && !$past(bus.atn))
		else $error("data delivered without listener");

	chk_dav_after_ready: assert property (
		$fell(pin_oe_n_ff.dav) |-> !$past(bus.nrfd, 2))
		else $error("data valid driven before ready");

	chk_dav_needs_talk: assert property (
		!pin_oe_n_ff.dav |-> $past(talker_ff))
		else $error("data valid driven while not talker");

	chk_acc_holds_nrfd: assert property (
		ah_st_ff == gpb_pkg::A_ACC |=> !pin_oe_n_ff.nrfd)
		else $error("not ready released while accepting");

	chk_srq_drive: assert property (
		rqs_set |=> rsv_ff ##1 !pin_oe_n_ff.srq)
		else $error("service request not driven");

	chk_gtl_local: assert property (
		cmd_ev && cmd == gpb_pkg::CMD_GTL && listener_ff && bus.ren |=> !remote_ff)
		else $error("go to local did not clear remote");

	chk_ignored_cmds: assert property (
		cmd_ev && !bus.ifc && !talk_only && (cmd == gpb_pkg::CMD_PPC
		|| cmd == gpb_pkg::CMD_PPU || cmd[6:5] == 2'b11)
		|=> $stable(listener_ff) && $stable(talker_ff) && !dev_clear_ff)
		else $error("ignored command changed state");

	cov_listen: cover property (cmd_ev && cmd == my_la ##[1:50] data_ev);
	cov_talk: cover property (tx_take ##[1:200] sh_done);
	cov_poll: cover property (spoll_ff && rsv_ff && sh_done);
	cov_trigger: cover property (trigger_ff);

endmodule

/* File: sim/gpb_ctl_model.sv */
`timescale 1ns/10ps

// ********************************
// Bus controller model
// ********************************
module gpb_ctl_model (
	// Clock
	input  wire logic                 mclk,
	// Wired bus levels, low is true
	input  wire gpb_pkg::gpb_bus_in_t wire_lvl,
	// Controller drive, low pulls the line
	output gpb_pkg::gpb_bus_in_t      ctl_drv
);
	localparam int LIM = 4000;

	initial ctl_drv = '1;

	task automatic lines(input logic atn, input logic ifc, input logic ren);
		@(negedge mclk);
		ctl_drv.atn = ~atn;
		ctl_drv.ifc = ~ifc;
		ctl_drv.ren = ~ren;
	endtask

	// commands and data
	// Both nrfd and ndac are checked, so a device whose acceptor is still off is never mistaken
	// for a ready one.
	task automatic send(input logic atn, input logic [7:0] b, output bit ok);
		int n;
		n = 0;
		@(negedge mclk);
		ctl_drv.atn = ~atn;
		while (!(wire_lvl.nrfd && !wire_lvl.ndac) && n < LIM) begin
			@(negedge mclk);
			n++;
		end
		ctl_drv.dio = ~b;
		repeat (2) @(negedge mclk);
		ctl_drv.dav = 1'b0;
		while (!wire_lvl.ndac && n < LIM) begin
			@(negedge mclk);
			n++;
		end
		ctl_drv.dav = 1'b1;
		ctl_drv.dio = 8'hFF;
		ok = n < LIM;
	endtask

	// slow acceptor
	// A valid strobe seen while this side still holds not-ready is reported as a failure.
	task automatic recv(input int lag, output logic [8:0] got, output bit ok);
		int n;
		n = 0;
		ok = 1'b1;
		@(negedge mclk);
		ctl_drv.ndac = 1'b0;
		ctl_drv.nrfd = 1'b0;
		for (int i = 0; i < lag; i++) begin
			@(negedge mclk);
			if (!wire_lvl.dav) ok = 1'b0;
		end
		ctl_drv.nrfd = 1'b1;
		while (wire_lvl.dav && n < LIM) begin
			@(negedge mclk);
			n++;
		end
		got = ~{wire_lvl.eoi, wire_lvl.dio};
		ctl_drv.nrfd = 1'b0;
		@(negedge mclk);
		ctl_drv.ndac = 1'b1;
		while (!wire_lvl.dav && n < LIM) begin
			@(negedge mclk);
			n++;
		end
		ctl_drv.nrfd = 1'b1;
		ok = ok && n < LIM;
	endtask
endmodule

/* File: sim/gpb_device_interface_functions_tb_top.sv */
`timescale 1ns/10ps

// ********************************
// Bench top
// ********************************
module gpb_device_interface_functions_tb_top;
	logic                 mclk, rst, talk_only, tx_end, tx_valid, rqs_set;
	logic [7:0]           tx_data, status, rx_data_ff;
	logic                 rx_valid_ff, rx_end_ff, tx_ready_ff, rsv_ff, listener_ff, talker_ff;
	logic                 remote_ff, spoll_ff, dev_clear_ff, trigger_ff;
	gpb_pkg::gpb_bus_in_t bus_in, ctl_drv;
	gpb_pkg::gpb_drv_t    pin_lvl_ff, pin_oe_n_ff, dw;
	int                   err_total, comparisons, n_clr, n_trg, n;
	logic [7:0]           rxq[$];
	logic [8:0]           got;
	bit                   ok;

	// A line is low when any party pulls it; released lines float high.
	assign dw = pin_oe_n_ff | pin_lvl_ff;
	assign bus_in = ctl_drv & {3'b111, dw[11:0]};

	always #20 mclk = ~mclk;

	always @(posedge mclk) begin
		if (rx_valid_ff === 1'b1) rxq.push_back(rx_data_ff);
		if (dev_clear_ff === 1'b1) n_clr++;
		if (trigger_ff === 1'b1) n_trg++;
	end

	gpb_dev gpb_dev_inst (.mclk(mclk), .rst(rst), .bus_in(bus_in), .pin_lvl_ff(pin_lvl_ff),
		.pin_oe_n_ff(pin_oe_n_ff), .prim_addr(5'h10), .talk_only(talk_only),
		.rx_data_ff(rx_data_ff), .rx_valid_ff(rx_valid_ff), .rx_end_ff(rx_end_ff),
		.tx_data(tx_data), .tx_end(tx_end), .tx_valid(tx_valid), .tx_ready_ff(tx_ready_ff),
		.status(status), .rqs_set(rqs_set), .rsv_ff(rsv_ff), .listener_ff(listener_ff),
		.talker_ff(talker_ff), .remote_ff(remote_ff), .spoll_ff(spoll_ff),
		.dev_clear_ff(dev_clear_ff), .trigger_ff(trigger_ff));

	gpb_ctl_model gpb_ctl_model_inst (.mclk(mclk), .wire_lvl(bus_in), .ctl_drv(ctl_drv));

	// ********************************
	// Checking
	// ********************************
	task automatic conclude();
		$display("comparisons %0d, mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
		comparisons++;
		if (seen !== exp) begin
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
			err_total++;
		end
	endtask

	task automatic need(input string what, input bit good);
		chk(what, 1, good);
		if (!good) conclude();
	endtask

	task automatic cmd(input logic [7:0] b);
		gpb_ctl_model_inst.send(1'b1, b, ok);
		need("command handshake", ok);
	endtask

	// ********************************
	// Scenarios
	// ********************************
	task automatic s_reset();
		chk("released lines", 16'h1FFF, pin_oe_n_ff);
		chk("states", 0, {listener_ff, talker_ff, remote_ff, spoll_ff, rsv_ff, tx_ready_ff});
	endtask

	task automatic s_listen();
		logic [7:0] msg[4];
		msg = '{8'h2A, 8'h52, 8'h53, 8'h54};
		gpb_ctl_model_inst.lines(1'b1, 1'b0, 1'b1);
		n_clr = 0;
		cmd(8'h04);
		chk("clear while unaddressed", 0, n_clr);
		cmd(8'h3F);
		cmd(8'h30);
		chk("listener", 1, listener_ff);
		chk("remote", 1, remote_ff);
		cmd(8'h04);
		chk("selective clear", 1, n_clr);
		rxq.delete();
		foreach (msg[i]) begin
			gpb_ctl_model_inst.send(1'b0, msg[i], ok);
			need("data handshake", ok);
		end
		chk("bytes taken", 4, rxq.size());
		foreach (msg[i]) chk("data byte", msg[i], rxq[i]);
		chk("end flag", 0, rx_end_ff);
	endtask

	task automatic s_cmds();
		n_clr = 0;
		n_trg = 0;
		cmd(8'h08);
		chk("trigger while listening", 1, n_trg);
		cmd(8'h05);
		cmd(8'h15);
		cmd(8'h70);
		chk("ignored commands", 2'b10, {listener_ff, talker_ff});
		chk("pulses", 16'h0001, {n_clr[7:0], n_trg[7:0]});
		cmd(8'h01);
		chk("go to local", 0, remote_ff);
		cmd(8'h50);
		chk("talk address", 2'b01, {listener_ff, talker_ff});
		cmd(8'h08);
		chk("trigger not listening", 1, n_trg);
		cmd(8'h30);
		chk("listen address", 2'b10, {listener_ff, talker_ff});
		cmd(8'h3F);
		cmd(8'h04);
		cmd(8'h14);
		chk("universal clear only", 1, n_clr);
		cmd(8'h50);
		cmd(8'h41);
		chk("other talk address", 0, talker_ff);
	endtask

	task automatic s_talk();
		gpb_ctl_model_inst.lines(1'b0, 1'b0, 1'b1);
		repeat (4) @(negedge mclk);
		chk("ready unaddressed", 0, tx_ready_ff);
		cmd(8'h50);
		gpb_ctl_model_inst.lines(1'b0, 1'b0, 1'b1);
		n = 0;
		while (tx_ready_ff !== 1'b1 && n < 50) begin
			@(negedge mclk);
			n++;
		end
		need("talker ready", tx_ready_ff === 1'b1);
		tx_data = 8'hA5;
		tx_end = 1'b1;
		tx_valid = 1'b1;
		@(negedge mclk);
		tx_valid = 1'b0;
		chk("ready after take", 0, tx_ready_ff);
		gpb_ctl_model_inst.recv(20, got, ok);
		need("talk handshake", ok);
		chk("talk byte", 9'h1A5, got);
	endtask

	task automatic s_spoll();
		gpb_ctl_model_inst.lines(1'b1, 1'b0, 1'b1);
		rqs_set = 1'b1;
		@(negedge mclk);
		rqs_set = 1'b0;
		repeat (3) @(negedge mclk);
		chk("request pending", 2'b10, {rsv_ff, dw.srq});
		cmd(8'h18);
		cmd(8'h50);
		gpb_ctl_model_inst.lines(1'b0, 1'b0, 1'b1);
		gpb_ctl_model_inst.recv(1, got, ok);
		need("poll handshake", ok);
		chk("poll byte", 8'hC1, got[7:0]);
		repeat (6) @(negedge mclk);
		chk("request served", 2'b01, {rsv_ff, dw.srq});
		gpb_ctl_model_inst.lines(1'b1, 1'b0, 1'b1);
		cmd(8'h19);
		cmd(8'h5F);
		chk("poll ended", 0, {spoll_ff, talker_ff});
	endtask

	task automatic s_ifc();
		logic [7:0] adr[2];
		adr = '{8'h30, 8'h50};
		foreach (adr[i]) begin
			cmd(adr[i]);
			gpb_ctl_model_inst.lines(1'b1, 1'b1, 1'b1);
			repeat (4) @(negedge mclk);
			chk("interface clear", 0, {listener_ff, talker_ff});
			gpb_ctl_model_inst.lines(1'b1, 1'b0, 1'b1);
		end
		cmd(8'h30);
		gpb_ctl_model_inst.lines(1'b1, 1'b0, 1'b0);
		repeat (4) @(negedge mclk);
		chk("remote enable dropped", 0, remote_ff);
		talk_only = 1'b1;
		repeat (4) @(negedge mclk);
		chk("talk only", 1, talker_ff);
		talk_only = 1'b0;
	endtask

	initial begin
		mclk = 1'b0;
		rst = 1'b1;
		talk_only = 1'b0;
		tx_end = 1'b0;
		tx_valid = 1'b0;
		rqs_set = 1'b0;
		tx_data = 8'h00;
		status = 8'h81;
		repeat (10) @(negedge mclk);
		s_reset();
		rst = 1'b0;
		repeat (3) @(negedge mclk);
		s_listen();
		s_cmds();
		s_talk();
		s_spoll();
		s_ifc();
		conclude();
	end
endmodule
